// >>> hw/aspc_core.sv
`timescale 1ns/1ps
module aspc_core
  import aspc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire aspc_bus_s  bus_i,
  output logic [7:0]      rdata_o,
  input  wire aspc_trig_s trig_i,
  input  wire logic       sck_i,
  input  wire logic       ws_i,
  input  wire logic       sd_rx_i,
  output logic            sck_o,
  output logic            sck_oe_o,
  output logic            ws_o,
  output logic            ws_oe_o,
  output logic            sd_tx_o
);

  function automatic logic [7:0] ulaw_enc(input logic [15:0] s);
    logic [15:0] m;
    logic [15:0] b;
    logic [2:0]  e;
    logic [3:0]  q;
    m = s[15] ? (~s + 16'h0001) : s;
    m = (m > 16'h7F7B) ? 16'h7F7B : m;
    b = m + 16'h0084;
    e = 3'h0;
    for (int i = 7; i >= 1; i--) begin
      if (e == 3'h0 && b[i + 7]) begin
        e = 3'(i);
      end
    end
    q = 4'(b >> ({1'b0, e} + 4'h3));
    return ~{s[15], e, q};
  endfunction : ulaw_enc

  function automatic logic [15:0] ulaw_dec(input logic [7:0] c);
    logic [7:0]  u;
    logic [15:0] t;
    u = ~c;
    t = (({12'h000, u[3:0]} << 3) + 16'h0084) << u[6:4];
    t = t - 16'h0084;
    return u[7] ? (~t + 16'h0001) : t;
  endfunction : ulaw_dec

  typedef struct packed {
    logic [7:0]  cfg0;
    logic [7:0]  cfg1;
    logic [7:0]  clkf0;
    logic [7:0]  clkf1;
    logic [7:0]  clkf2;
    logic [15:0] dat;
    logic        datl_wr;
    logic [7:0]  word_count_snapshot;
    logic [1:0]  word_count_snapshot_hi;
    logic [9:0]  ctr;
    logic        txunf;
    logic        rxovf;
    logic        txlr;
    logic        rxlr;
    logic        txirq;
    logic        rxirq;
    logic        cmp_go;
    logic        exp_go;
    logic [15:0] txbuf;
    logic        txfull;
    logic [15:0] txsh;
    logic [5:0]  txcnt;
    logic        tx_repeat;
    logic [15:0] rxsh;
    logic [5:0]  rxcnt;
    logic [15:0] rxbuf;
    logic        rxfull;
    logic [16:0] acc;
    logic        msck;
    logic        mws;
    logic [5:0]  mbit;
    logic [1:0]  sck_s;
    logic [1:0]  ws_s;
    logic [1:0]  sd_s;
    logic [1:0]  sof_s;
    logic [1:0]  pin_s;
    logic [1:0]  tmr_s;
    logic        sck_p;
    logic        ws_p;
    logic        sof_p;
    logic        pin_p;
    logic        tmr_p;
    logic        ws_lat;
    logic        tx_out;
    logic [7:0]  rdata;
  } aspc_state_s;

  aspc_state_s q_q;
  aspc_state_s d_d;

  logic [14:0] num;
  logic [8:0]  den;
  logic        master;
  logic        enable;
  logic [5:0]  wlen;
  logic        sck_now;
  logic        ws_now;
  logic        rise;
  logic        fall;
  logic        ws_edge;
  logic        trig;
  logic [15:0] rx_word;

  assign num    = {q_q.clkf2[6:0], q_q.clkf1};
  assign den    = {q_q.clkf2[7], q_q.clkf0};
  assign master = q_q.cfg0[CFG0_MASTER];
  assign enable = q_q.cfg0[CFG0_ENABLE];
  assign wlen   = {1'b0, q_q.cfg1[7:3]} + 6'h01;
  assign sck_now = master ? q_q.msck : q_q.sck_s[1];
  assign ws_now  = master ? q_q.mws : q_q.ws_s[1];
  assign rise    = sck_now & ~q_q.sck_p;
  assign fall    = ~sck_now & q_q.sck_p;
  assign ws_edge = rise & (q_q.ws_lat != ws_now);

  always_comb begin
    case (q_q.cfg1[2:1])
      TRIG_SOF: trig = q_q.sof_s[1] & ~q_q.sof_p;
      TRIG_PIN: trig = q_q.pin_s[1] ^ q_q.pin_p;
      TRIG_TMR: trig = q_q.tmr_s[1] & ~q_q.tmr_p;
      default:  trig = 1'b0;
    endcase
  end

  always_comb begin
    d_d = q_q;
    rx_word = 16'h0000;
    d_d.sck_s = {q_q.sck_s[0], sck_i};
    d_d.ws_s  = {q_q.ws_s[0], ws_i};
    d_d.sd_s  = {q_q.sd_s[0], sd_rx_i};
    d_d.sof_s = {q_q.sof_s[0], trig_i.sof};
    d_d.pin_s = {q_q.pin_s[0], trig_i.pin};
    d_d.tmr_s = {q_q.tmr_s[0], trig_i.tmr};
    d_d.sof_p = q_q.sof_s[1];
    d_d.pin_p = q_q.pin_s[1];
    d_d.tmr_p = q_q.tmr_s[1];
    d_d.sck_p = sck_now;
    d_d.cmp_go = 1'b0;
    d_d.exp_go = 1'b0;

    // half period is num over den
    if (master && enable) begin
      if ({1'b0, q_q.acc} + {8'h00, den} >= {2'b00, num}) begin
        d_d.acc  = 17'({1'b0, q_q.acc} + {8'h00, den} - {2'b00, num});
        d_d.msck = ~q_q.msck;
        if (q_q.msck) begin
          // select flips before the last bit
          if (q_q.mbit == wlen - 6'h02 || wlen == 6'h01) begin
            d_d.mws = ~q_q.mws;
          end
          d_d.mbit = (q_q.mbit + 6'h01 >= wlen) ? 6'h00 : q_q.mbit + 6'h01;
        end
      end else begin
        d_d.acc = q_q.acc + {8'h00, den};
      end
    end else begin
      d_d.acc  = 17'h0_0000;
      d_d.msck = 1'b0;
      d_d.mbit = 6'h00;
    end

    if (enable && fall) begin
      // MSB first, data changes on falling edge
      if (q_q.ws_lat != ws_now) begin
        d_d.txcnt = 6'h00;
      end
      if (q_q.txcnt < TX_BITS) begin
        d_d.tx_out = q_q.txsh[15];
        d_d.txsh   = {q_q.txsh[14:0], 1'b0};
        d_d.txcnt  = q_q.txcnt + 6'h01;
      end else begin
        d_d.tx_out = 1'b0;
      end
    end

    if (enable && rise) begin
      d_d.ws_lat = ws_now;
      if (q_q.rxcnt < TX_BITS) begin
        d_d.rxsh  = {q_q.rxsh[14:0], q_q.sd_s[1]};
        d_d.rxcnt = q_q.rxcnt + 6'h01;
      end
      // The bit sampled with the new select still ends the old word.
      if (ws_edge) begin
        if (q_q.ctr != WORD_COUNT_SNAPSHOT_MAX) begin
          d_d.ctr = q_q.ctr + 10'h001;
        end
        rx_word   = d_d.rxsh << (TX_BITS - d_d.rxcnt);
        d_d.rxcnt = 6'h00;
        d_d.rxsh  = 16'h0000;
        if (!(q_q.cfg0[CFG0_RX_SINGLE_CHANNEL] && q_q.ws_lat)) begin
          d_d.rxbuf = rx_word;
          d_d.rxlr  = q_q.ws_lat;
          if (q_q.rxirq) begin
            d_d.rxovf = 1'b1;
          end
          if (q_q.cfg0[CFG0_COMPR]) begin
            d_d.dat = {ulaw_enc(rx_word), 8'h00};
          end else begin
            d_d.dat = rx_word;
          end
          d_d.rxirq = 1'b1;
        end
        // mono repeats word in right slot
        d_d.txcnt = 6'h00;
        if (q_q.cfg0[CFG0_TX_SINGLE_CHANNEL] && !q_q.tx_repeat && ws_now) begin
          d_d.txsh      = q_q.txbuf;
          d_d.tx_repeat = 1'b1;
        end else begin
          d_d.tx_repeat = 1'b0;
          if (!q_q.txfull) begin
            d_d.txunf = 1'b1;
          end
          d_d.txsh   = q_q.txbuf;
          d_d.txfull = 1'b0;
          d_d.txirq  = 1'b1;
          d_d.txlr   = q_q.cfg0[CFG0_TX_SINGLE_CHANNEL] ? 1'b0 : ~ws_now;
        end
      end
    end

    if (trig) begin
      d_d.word_count_snapshot    = q_q.ctr[7:0];
      d_d.word_count_snapshot_hi = q_q.ctr[9:8];
      d_d.ctr     = 10'h000;
    end

    if (q_q.exp_go) begin
      d_d.dat = ulaw_dec(q_q.dat[15:8]);
    end
    if (q_q.cmp_go) begin
      d_d.dat = {ulaw_enc(q_q.dat), q_q.dat[7:0]};
    end

    d_d.rdata = 8'h00;
    if (bus_i.rd) begin
      case (bus_i.addr)
        ADDR_CFG0:  d_d.rdata = q_q.cfg0;
        ADDR_CFG1:  d_d.rdata = q_q.cfg1;
        ADDR_DATL:  d_d.rdata = q_q.dat[7:0];
        ADDR_DATH: begin
          d_d.rdata = q_q.dat[15:8];
          d_d.rxirq = d_d.rxirq & ~q_q.rxirq;
        end
        ADDR_WORD_COUNT_SNAPSHOT:  d_d.rdata = q_q.word_count_snapshot;
        ADDR_STAT:  d_d.rdata = {q_q.txunf, q_q.rxovf, q_q.txlr, q_q.rxlr,
                                 q_q.txirq, q_q.rxirq, q_q.word_count_snapshot_hi};
        ADDR_CLKF0: d_d.rdata = q_q.clkf0;
        ADDR_CLKF1: d_d.rdata = q_q.clkf1;
        ADDR_CLKF2: d_d.rdata = q_q.clkf2;
        default:    d_d.rdata = 8'h00;
      endcase
    end

    if (bus_i.wr) begin
      case (bus_i.addr)
        ADDR_CFG0:  d_d.cfg0 = bus_i.wdata;
        ADDR_CFG1:  d_d.cfg1 = bus_i.wdata;
        ADDR_DATL: begin
          d_d.dat[7:0] = bus_i.wdata;
          d_d.datl_wr  = 1'b1;
        end
        ADDR_DATH: begin
          d_d.dat[15:8] = bus_i.wdata;
          d_d.datl_wr   = 1'b0;
          d_d.txirq     = d_d.txirq & ~q_q.txirq;
          d_d.txfull    = 1'b1;
          if (q_q.cfg0[CFG0_EXPAND]) begin
            d_d.txbuf = ulaw_dec(bus_i.wdata);
          end else begin
            d_d.txbuf = {bus_i.wdata, q_q.datl_wr ? q_q.dat[7:0] : 8'h00};
          end
          d_d.exp_go = ~enable & q_q.cfg0[CFG0_EXPAND];
          d_d.cmp_go = ~enable & q_q.cfg0[CFG0_COMPR];
        end
        ADDR_WORD_COUNT_SNAPSHOT: begin
          d_d.word_count_snapshot    = q_q.ctr[7:0];
          d_d.word_count_snapshot_hi = q_q.ctr[9:8];
          d_d.ctr     = 10'h000;
        end
        ADDR_STAT: begin
          // A flag set by hardware in this cycle survives the write.
          d_d.txunf = bus_i.wdata[7] | (d_d.txunf & ~q_q.txunf);
          d_d.rxovf = bus_i.wdata[6] | (d_d.rxovf & ~q_q.rxovf);
          d_d.txirq = bus_i.wdata[3] | (d_d.txirq & ~q_q.txirq);
          d_d.rxirq = bus_i.wdata[2] | (d_d.rxirq & ~q_q.rxirq);
        end
        ADDR_CLKF0: d_d.clkf0 = bus_i.wdata;
        ADDR_CLKF1: d_d.clkf1 = bus_i.wdata;
        ADDR_CLKF2: d_d.clkf2 = bus_i.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q_q       <= '0;
      q_q.cfg0  <= CFG0_RST;
      q_q.cfg1  <= CFG1_RST;
      q_q.clkf0 <= CLKF0_RST;
      q_q.clkf1 <= CLKF1_RST;
      q_q.clkf2 <= CLKF2_RST;
    end else begin
      q_q <= d_d;
    end
  end

  // master drives the clock and select
  assign sck_o    = q_q.msck;
  assign ws_o     = q_q.mws;
  assign sck_oe_o = master;
  assign ws_oe_o  = master;
  assign sd_tx_o  = q_q.tx_out;
  assign rdata_o  = q_q.rdata;

  AST_WORD_COUNT_SNAPSHOT_SAT: assert property (@(posedge clk_i) disable iff (srst_i)
    (q_q.ctr == WORD_COUNT_SNAPSHOT_MAX && !trig && !(bus_i.wr && bus_i.addr == ADDR_WORD_COUNT_SNAPSHOT))
    |=> q_q.ctr == WORD_COUNT_SNAPSHOT_MAX) else $error("word counter wrapped");
  AST_WORD_COUNT_SNAPSHOT_COPY: assert property (@(posedge clk_i) disable iff (srst_i)
    (bus_i.wr && bus_i.addr == ADDR_WORD_COUNT_SNAPSHOT) |=>
    q_q.ctr == 10'h000 && {q_q.word_count_snapshot_hi, q_q.word_count_snapshot} == $past(q_q.ctr))
    else $error("word count copy failed");
  AST_NO_TRIG: assert property (@(posedge clk_i) disable iff (srst_i)
    q_q.cfg1[2:1] == TRIG_NONE |-> !trig)
    else $error("trigger fired while none selected");
  AST_OE_MASTER: assert property (@(posedge clk_i) disable iff (srst_i)
    sck_oe_o == q_q.cfg0[CFG0_MASTER] && ws_oe_o == sck_oe_o)
    else $error("output enable does not follow master");
  AST_EXP_ONE: assert property (@(posedge clk_i) disable iff (srst_i)
    (bus_i.wr && bus_i.addr == ADDR_DATH && !enable &&
     q_q.cfg0[CFG0_EXPAND] && !q_q.cfg0[CFG0_COMPR])
    |=> ##1 q_q.dat == ulaw_dec($past(bus_i.wdata, 2)))
    else $error("standalone expansion wrong");
  AST_CMP_ONE: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(q_q.cmp_go) && !q_q.cfg0[CFG0_EXPAND]
    |=> q_q.dat[15:8] == ulaw_enc($past(q_q.dat)))
    else $error("standalone compression wrong");
  AST_SLAVE_IDLE: assert property (@(posedge clk_i) disable iff (srst_i)
    !master |=> !q_q.msck)
    else $error("slave mode generated a clock");
  AST_CFG1_RST: assert property (@(posedge clk_i)
    $fell(srst_i) |-> q_q.cfg1[7:3] == 5'h0F && q_q.cfg0 == 8'h00)
    else $error("reset values wrong");

endmodule : aspc_core

// >>> pkg/aspc_pkg.sv
package aspc_pkg;

  // Register addresses in the data memory space.
  localparam logic [15:0] ADDR_CFG0   = 16'hDF40;
  localparam logic [15:0] ADDR_CFG1   = 16'hDF41;
  localparam logic [15:0] ADDR_DATL   = 16'hDF42;
  localparam logic [15:0] ADDR_DATH   = 16'hDF43;
  localparam logic [15:0] ADDR_WORD_COUNT_SNAPSHOT   = 16'hDF44;
  localparam logic [15:0] ADDR_STAT   = 16'hDF45;
  localparam logic [15:0] ADDR_CLKF0  = 16'hDF46;
  localparam logic [15:0] ADDR_CLKF1  = 16'hDF47;
  localparam logic [15:0] ADDR_CLKF2  = 16'hDF48;

  // Configuration register 0 field positions.
  localparam int CFG0_TX_IRQ_ENABLE  = 7;
  localparam int CFG0_RX_IRQ_ENABLE  = 6;
  localparam int CFG0_EXPAND = 5;
  localparam int CFG0_COMPR  = 4;
  localparam int CFG0_TX_SINGLE_CHANNEL = 3;
  localparam int CFG0_RX_SINGLE_CHANNEL = 2;
  localparam int CFG0_MASTER = 1;
  localparam int CFG0_ENABLE = 0;

  // Reset values.
  localparam logic [7:0] CFG0_RST  = 8'h00;
  localparam logic [7:0] CFG1_RST  = 8'h78;
  localparam logic [7:0] CLKF0_RST = 8'h93;
  localparam logic [7:0] CLKF1_RST = 8'hE2;
  localparam logic [7:0] CLKF2_RST = 8'h04;

  // Word counter trigger selection.
  localparam logic [1:0] TRIG_NONE = 2'b00;
  localparam logic [1:0] TRIG_SOF  = 2'b01;
  localparam logic [1:0] TRIG_PIN  = 2'b10;
  localparam logic [1:0] TRIG_TMR  = 2'b11;

  localparam logic [9:0] WORD_COUNT_SNAPSHOT_MAX = 10'h3FF;
  localparam logic [5:0] TX_BITS  = 6'h10;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } aspc_bus_s;

  typedef struct packed {
    logic sof;
    logic pin;
    logic tmr;
  } aspc_trig_s;

endpackage : aspc_pkg

// >>> sim/aspc_audio_dev.sv
`timescale 1ns/1ps
module aspc_audio_dev #(
  parameter logic [19:0] RX_PATTERN = 20'hC_3A59
) (
  input  wire logic        sck_i,
  input  wire logic        ws_i,
  input  wire logic        sd_i,
  output logic             sd_o,
  output logic [31:0]      left_word_o,
  output logic [31:0]      right_word_o,
  output logic [5:0]       left_len_o,
  output logic [5:0]       right_len_o,
  output logic [15:0]      words_o
);
  logic [31:0] shift_q;
  logic [5:0]  len_q;
  logic        ws_rise_q;
  logic        ws_fall_q;
  int          nxt_q;

  initial begin
    sd_o         = 1'b0;
    left_word_o  = '0;
    right_word_o = '0;
    left_len_o   = '0;
    right_len_o  = '0;
    words_o      = '0;
    shift_q      = '0;
    len_q        = '0;
    ws_rise_q    = 1'b0;
    ws_fall_q    = 1'b0;
    nxt_q        = -1;
  end

  // Capture MSB first; the bit after a select flip ends a word.
  always @(posedge sck_i) begin
    #1;
    if (ws_i !== ws_rise_q) begin
      if (ws_rise_q) begin
        right_word_o = {shift_q[30:0], sd_i};
        right_len_o  = len_q + 6'h1;
      end else begin
        left_word_o = {shift_q[30:0], sd_i};
        left_len_o  = len_q + 6'h1;
      end
      words_o = words_o + 16'h1;
      shift_q = '0;
      len_q   = '0;
    end else begin
      shift_q = {shift_q[30:0], sd_i};
      len_q   = len_q + 6'h1;
    end
    ws_rise_q = ws_i;
  end

  // Drive MSB first after the falling edge; zeros once sent out.
  always @(negedge sck_i) begin
    #1;
    if (ws_i !== ws_fall_q) begin
      sd_o  = RX_PATTERN[0];
      nxt_q = 19;
    end else if (nxt_q > 0) begin
      sd_o  = RX_PATTERN[nxt_q];
      nxt_q = nxt_q - 1;
    end else begin
      sd_o = 1'b0;
    end
    ws_fall_q = ws_i;
  end
endmodule : aspc_audio_dev

// >>> sim/aspc_core_tb.sv
`timescale 1ns/1ps
module aspc_core_tb;
  import aspc_pkg::*;
  logic        clk_i;
  logic        srst_i;
  aspc_bus_s   bus_q;
  aspc_trig_s  trig_q;
  logic [7:0]  rdata;
  logic        sck, sck_oe, ws, ws_oe, sd_tx, sd_rx;
  logic        sck_m, ws_m, slv_sck, slv_ws, slv_run;
  logic [4:0]  slv_bit;
  logic [2:0]  slv_div;
  logic [31:0] left_w, right_w;
  logic [5:0]  left_n, right_n;
  logic [15:0] words;
  logic [7:0]  v;
  int          err_total;
  int          checks_done;
  int          n;

  aspc_core dut_u (.clk_i(clk_i), .srst_i(srst_i), .bus_i(bus_q),
    .rdata_o(rdata), .trig_i(trig_q), .sck_i(sck), .ws_i(ws),
    .sd_rx_i(sd_rx), .sck_o(sck_m), .sck_oe_o(sck_oe), .ws_o(ws_m),
    .ws_oe_o(ws_oe), .sd_tx_o(sd_tx));

  aspc_audio_dev dev_u (.sck_i(sck), .ws_i(ws), .sd_i(sd_tx), .sd_o(sd_rx),
    .left_word_o(left_w), .right_word_o(right_w), .left_len_o(left_n),
    .right_len_o(right_n), .words_o(words));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  assign sck = sck_oe ? sck_m : slv_sck;
  assign ws  = ws_oe ? ws_m : slv_ws;

  // Slave-side master: select flips before the last of 20 bits.
  always @(posedge clk_i) begin
    if (!slv_run) begin
      slv_div <= 3'h0;
      slv_sck <= 1'b0;
      slv_ws  <= 1'b0;
      slv_bit <= 5'h00;
    end else if (slv_div != 3'h7) begin
      slv_div <= slv_div + 3'h1;
    end else begin
      slv_div <= 3'h0;
      slv_sck <= ~slv_sck;
      if (slv_sck) begin
        slv_bit <= (slv_bit == 5'h13) ? 5'h00 : slv_bit + 5'h01;
        slv_ws  <= (slv_bit == 5'h12) ? ~slv_ws : slv_ws;
      end
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic chk_val(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s exp %h got %h", name, exp, got);
    end
  endtask : chk_val

  task automatic wr_reg(input logic [15:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    bus_q.wr    <= 1'b1;
    bus_q.addr  <= addr;
    bus_q.wdata <= data;
    @(posedge clk_i);
    bus_q.wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] addr, output logic [7:0] data);
    @(posedge clk_i);
    bus_q.rd   <= 1'b1;
    bus_q.addr <= addr;
    @(posedge clk_i);
    bus_q.rd <= 1'b0;
    #1;
    data = rdata;
  endtask : rd_reg

  task automatic rd_chk(input string name, input logic [15:0] addr,
                        input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(addr, d);
    chk_val(name, {24'h00_0000, exp}, {24'h00_0000, d});
  endtask : rd_chk

  task automatic wait_ws(input int cnt);
    int   k;
    logic w0;
    for (int i = 0; i < cnt; i++) begin
      k  = 0;
      w0 = ws;
      while (ws === w0 && k < 1000) begin
        @(posedge clk_i);
        k++;
      end
      if (k >= 1000) begin
        err_total++;
        test_done();
      end
    end
    repeat (8) @(posedge clk_i);
  endtask : wait_ws

  task automatic sck_period(output int cnt);
    int k;
    k = 0;
    while (sck !== 1'b0 && k < 64) begin @(posedge clk_i); #1; k++; end
    while (sck !== 1'b1 && k < 64) begin @(posedge clk_i); #1; k++; end
    if (k >= 64) err_total++;
    cnt = 0;
    while (sck !== 1'b0 && cnt < 64) begin @(posedge clk_i); #1; cnt++; end
    while (sck !== 1'b1 && cnt < 64) begin @(posedge clk_i); #1; cnt++; end
  endtask : sck_period

  initial begin
    srst_i      = 1'b1;
    slv_run     = 1'b0;
    bus_q       = '0;
    trig_q      = '0;
    err_total   = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    rd_chk("cfg0", ADDR_CFG0, 8'h00);
    rd_chk("cfg1", ADDR_CFG1, 8'h78);
    rd_chk("clkf0", ADDR_CLKF0, 8'h93);
    rd_chk("clkf1", ADDR_CLKF1, 8'hE2);
    rd_chk("clkf2", ADDR_CLKF2, 8'h04);
    rd_chk("unmapped", 16'hDF49, 8'h00);
    wr_reg(ADDR_CFG0, 8'h20);
    wr_reg(ADDR_DATH, 8'hFF);
    repeat (2) @(posedge clk_i);
    rd_chk("expand low", ADDR_DATL, 8'h00);
    rd_chk("expand high", ADDR_DATH, 8'h00);
    wr_reg(ADDR_CFG0, 8'h10); // compression alone
    wr_reg(ADDR_DATL, 8'h00);
    wr_reg(ADDR_DATH, 8'h00);
    repeat (2) @(posedge clk_i);
    rd_chk("compress", ADDR_DATH, 8'hFF);
    // Divider ratio 4 and 20-bit words before master.
    wr_reg(ADDR_CFG0, 8'h00);
    wr_reg(ADDR_CLKF0, 8'h01);
    wr_reg(ADDR_CLKF1, 8'h04);
    wr_reg(ADDR_CLKF2, 8'h00);
    wr_reg(ADDR_CFG1, 8'h98);
    wr_reg(ADDR_CFG0, 8'h0F);
    wr_reg(ADDR_DATL, 8'h3C);
    wr_reg(ADDR_DATH, 8'hA5);
    wait_ws(8);
    chk_val("pin enables", 32'h0000_0003, {30'h0, sck_oe, ws_oe});
    chk_val("left word", 32'h000A_53C0, left_w);
    chk_val("right word", 32'h000A_53C0, right_w);
    chk_val("left length", 32'h0000_0014, {26'h0, left_n});
    chk_val("right length", 32'h0000_0014, {26'h0, right_n});
    sck_period(n);
    chk_val("sck period", 32'h0000_0008, n);
    rd_chk("rx low", ADDR_DATL, 8'hA5);
    rd_chk("rx high", ADDR_DATH, 8'hC3);
    for (int c = 1; c < 4; c++) begin
      wr_reg(ADDR_CFG1, {5'h13, c[1:0], 1'b0});
      wait_ws(1);
      wr_reg(ADDR_WORD_COUNT_SNAPSHOT, 8'h00);
      wait_ws(4);
      trig_q <= aspc_trig_s'({c == 1, c == 2, c == 3});
      repeat (8) @(posedge clk_i);
      rd_chk("trigger count", ADDR_WORD_COUNT_SNAPSHOT, 8'h04);
      rd_reg(ADDR_STAT, v);
      chk_val("count high", 32'h0, {30'h0, v[1:0]});
      @(posedge clk_i);
      trig_q <= '0;
    end
    wr_reg(ADDR_CFG1, 8'h98);
    wait_ws(1);
    wr_reg(ADDR_WORD_COUNT_SNAPSHOT, 8'h00);
    wait_ws(2);
    trig_q <= aspc_trig_s'(3'b111);
    wait_ws(2);
    wr_reg(ADDR_WORD_COUNT_SNAPSHOT, 8'h00);
    rd_chk("soft count", ADDR_WORD_COUNT_SNAPSHOT, 8'h04);
    // Slave mode with both companding enables on a live link.
    wr_reg(ADDR_CFG0, 8'h3D);
    slv_run <= 1'b1;
    wr_reg(ADDR_DATH, 8'h80);
    wait_ws(8);
    chk_val("slave enables", 32'h0, {30'h0, sck_oe, ws_oe});
    chk_val("slave left word", 32'h0007_D7C0, left_w);
    chk_val("slave right word", 32'h0007_D7C0, right_w);
    rd_chk("slave compressed", ADDR_DATH, 8'h11);
    test_done();
  end
endmodule : aspc_core_tb
